//--- hw/dpgs_regs.sv
`timescale 1ns/100ps
// Function
// - power-down control registers at volatile 09h and nonvolatile 19h
// - power-down field bits 1-0 single, 3-0 dual; channel 0 low pair
// - field 00 runs normally, 11 powers down with output open
// - field 10 powers down with 100k pull-down, 01 with 1k
// - volatile gain plus status register at 0Ah
// - gain select bit 8 channel 0, bit 9 channel 1; one doubles
// - reset-event flag bit 7 set by power-on or brown-out reset
// - any read of gain/status register clears reset-event flag
// - read-only bit 6 shows a nonvolatile write in progress
// - during nonvolatile write only volatile commands accepted
// - nonvolatile gain register at 1Ah, same gain bit layout
// - unimplemented bits, single-part channel 1 fields, read zero
// - volatile configuration writable when only nonvolatile locked
// - bad command or address errors until frame ends
module dpgs_regs
    import dpgs_pkg::*;
#(
    parameter bit DUAL = 1'b1
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [4:0]  cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        cmd_frame_end,
    input  wire logic [1:0]  lock_config_bits,
    output logic             cmd_ready,
    output logic             cmd_done,
    output logic             cmd_error,
    output logic      [15:0] cmd_rdata,
    output logic      [3:0]  channel_power_down_select,
    output logic             ch0_gain_select,
    output logic             ch1_gain_select,
    output logic             nv_write_active_flag,
    output logic      [1:0]  out_drive_en,
    output logic      [1:0]  out_pull_1k,
    output logic      [1:0]  out_pull_100k,
    output logic      [1:0]  out_gain_x2
);

    localparam logic [3:0] PD_MASK   = DUAL ? PD_MASK_DUAL : PD_MASK_SINGLE;
    localparam logic [1:0] GAIN_MASK = DUAL ? GAIN_MASK_DUAL : GAIN_MASK_SGL;

    typedef struct packed {
        dpgs_state_t state;
        logic [3:0]  pd;
        logic [1:0]  gain;
        logic        por;
        logic        done;
        logic        err;
        logic [15:0] rdata;
    } dpgs_regs_t;

    dpgs_regs_t s_q;
    dpgs_regs_t s_d;

    logic       nv_busy;
    logic [3:0] nv_pd;
    logic [1:0] nv_gain;
    logic       nv_wr_pd;
    logic       nv_wr_gain;

    // ------------------------------------------------------------
    // address decode and read word helpers
    // ------------------------------------------------------------
    function automatic logic addr_known(input logic [4:0] a);
        return (a == PD_VOL_ADDR) || (a == GAIN_STAT_ADDR) ||
               (a == PD_NV_ADDR)  || (a == GAIN_NV_ADDR);
    endfunction

    function automatic logic addr_is_nv(input logic [4:0] a);
        return (a == PD_NV_ADDR) || (a == GAIN_NV_ADDR);
    endfunction

    function automatic logic [15:0] pd_word(input logic [3:0] v);
        return {12'h000, v & PD_MASK};
    endfunction

    function automatic logic [15:0] gain_word(input logic [1:0] v);
        logic [15:0] w;
        w = 16'h0000;
        w[GAIN_LSB +: 2] = v & GAIN_MASK;
        return w;
    endfunction

    // ------------------------------------------------------------
    // command acceptance
    // ------------------------------------------------------------
    logic cmd_take;
    logic bad_cmd;
    logic wr_ok;
    logic vol_locked;
    logic nv_locked;

    // only all-locked blocks volatile config, keeps power-down usable
    assign vol_locked = (lock_config_bits == LOCK_ALL);
    assign nv_locked  = (lock_config_bits != LOCK_NONE);
    assign cmd_ready  = (s_q.state == DPGS_RUN);
    assign cmd_take   = cmd_valid && cmd_ready;

    // unknown address, nonvolatile access while writing, locked write
    always_comb
    begin
        bad_cmd = !addr_known(cmd_addr);
        if (addr_is_nv(cmd_addr) && nv_busy)
        begin
            bad_cmd = 1'b1;
        end
        if (cmd_write && addr_is_nv(cmd_addr) && nv_locked)
        begin
            bad_cmd = 1'b1;
        end
        if (cmd_write && !addr_is_nv(cmd_addr) && vol_locked)
        begin
            bad_cmd = 1'b1;
        end
    end

    assign wr_ok      = cmd_take && cmd_write && !bad_cmd;
    assign nv_wr_pd   = wr_ok && (cmd_addr == PD_NV_ADDR);
    assign nv_wr_gain = wr_ok && (cmd_addr == GAIN_NV_ADDR);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.err  = 1'b0;
        case (s_q.state)
            DPGS_LOAD:
            begin
                // recall before any command can see the old defaults
                s_d.pd    = nv_pd & PD_MASK;
                s_d.gain  = nv_gain & GAIN_MASK;
                s_d.state = DPGS_RUN;
            end
            DPGS_RUN:
            begin
                if (cmd_take && bad_cmd)
                begin
                    s_d.err   = 1'b1;
                    s_d.state = DPGS_ERR;
                end
                else if (cmd_take)
                begin
                    s_d.done = 1'b1;
                    if (cmd_write)
                    begin
                        if (cmd_addr == PD_VOL_ADDR)
                        begin
                            s_d.pd = cmd_wdata[PD_LSB +: 4] & PD_MASK;
                        end
                        if (cmd_addr == GAIN_STAT_ADDR)
                        begin
                            // status bits 7 and 6 ignore writes
                            s_d.gain = cmd_wdata[GAIN_LSB +: 2]
                                       & GAIN_MASK;
                        end
                    end
                    else
                    begin
                        case (cmd_addr)
                            PD_VOL_ADDR:
                                s_d.rdata = pd_word(s_q.pd);
                            PD_NV_ADDR:
                                s_d.rdata = pd_word(nv_pd);
                            GAIN_NV_ADDR:
                                s_d.rdata = gain_word(nv_gain);
                            GAIN_STAT_ADDR:
                            begin
                                s_d.rdata = gain_word(s_q.gain);
                                s_d.rdata[POR_BIT]  = s_q.por;
                                s_d.rdata[NVWA_BIT] = nv_busy;
                                s_d.por = 1'b0;
                            end
                            default:
                                s_d.rdata = RDATA_RESET;
                        endcase
                    end
                end
            end
            DPGS_ERR:
            begin
                // stuck until the host ends the frame
                if (cmd_frame_end)
                begin
                    s_d.state = DPGS_RUN;
                end
            end
            default:
            begin
                s_d.state = DPGS_LOAD;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register; reset stands for the power-on/brown-out event
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q.state <= DPGS_LOAD;
            s_q.pd    <= PD_RESET;
            s_q.gain  <= GAIN_RESET;
            s_q.por   <= 1'b1;
            s_q.done  <= 1'b0;
            s_q.err   <= 1'b0;
            s_q.rdata <= RDATA_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    dpgs_nv_store u_nv (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .wr_pd       (nv_wr_pd),
        .wr_gain     (nv_wr_gain),
        .wr_pd_val   (cmd_wdata[PD_LSB +: 4] & PD_MASK),
        .wr_gain_val (cmd_wdata[GAIN_LSB +: 2] & GAIN_MASK),
        .nv_pd       (nv_pd),
        .nv_gain     (nv_gain),
        .busy        (nv_busy)
    );

    dpgs_out_decode u_dec (
        .pd_sel        (s_q.pd),
        .gain_sel      (s_q.gain),
        .out_drive_en  (out_drive_en),
        .out_pull_1k   (out_pull_1k),
        .out_pull_100k (out_pull_100k),
        .out_gain_x2   (out_gain_x2)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cmd_done                  = s_q.done;
    assign cmd_error                 = s_q.err;
    assign cmd_rdata                 = s_q.rdata;
    assign channel_power_down_select = s_q.pd;
    assign ch0_gain_select           = s_q.gain[0];
    assign ch1_gain_select           = s_q.gain[1];
    assign nv_write_active_flag      = nv_busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pd_vol_write: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_take && cmd_write && !bad_cmd && cmd_addr == PD_VOL_ADDR
        |=> channel_power_down_select == ($past(cmd_wdata[3:0]) & PD_MASK))
        else $error("volatile power-down write not applied");

    a_pd_mask_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (channel_power_down_select & ~PD_MASK) == 4'h0)
        else $error("power-down bits set outside channel fields");

    a_open_circuit: assert property (@(posedge sys_clk) disable iff (rst)
        channel_power_down_select[1:0] == PD_OPEN |->
        !out_drive_en[0] && !out_pull_1k[0] && !out_pull_100k[0])
        else $error("open circuit mode drives or loads output");

    a_pull_select: assert property (@(posedge sys_clk) disable iff (rst)
        out_pull_100k[0] == (channel_power_down_select[1:0] == PD_PULL_100K)
        && out_pull_1k[0] == (channel_power_down_select[1:0] == PD_PULL_1K))
        else $error("pull-down selection mismatch");

    a_gain_read: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_take && !cmd_write && cmd_addr == GAIN_STAT_ADDR
        |=> cmd_rdata[GAIN_LSB +: 2] == {ch1_gain_select, ch0_gain_select})
        else $error("gain bits read back wrong");

    a_por_clear: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_take && !cmd_write && cmd_addr == GAIN_STAT_ADDR
        |=> !s_q.por ##1 !s_q.por)
        else $error("reset-event flag not cleared by read");

    a_nvwa_read: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_take && !cmd_write && cmd_addr == GAIN_STAT_ADDR
        |=> cmd_rdata[NVWA_BIT] == $past(nv_busy))
        else $error("write-active bit does not show write state");

    a_nv_busy_err: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_take && nv_busy && addr_is_nv(cmd_addr)
        |=> cmd_error && !cmd_done ##1 !cmd_ready)
        else $error("nonvolatile access accepted during write");

    a_unused_zero: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_rdata[15:10] == 6'h00 && cmd_rdata[5:4] == 2'h0)
        else $error("unimplemented bits read nonzero");

    a_vol_unlock: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_take && cmd_write && cmd_addr == PD_VOL_ADDR
        && lock_config_bits != LOCK_ALL |=> cmd_done)
        else $error("volatile config write refused while permitted");

    a_bad_addr: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_take && !addr_known(cmd_addr) |=> cmd_error ##1 !cmd_ready)
        else $error("unmapped address not flagged");

    a_recall: assert property (@(posedge sys_clk)
        $fell(rst) |=> channel_power_down_select == (nv_pd & PD_MASK))
        else $error("power-down not recalled after reset");

endmodule // dpgs_regs

//--- hw/dpgs_pkg.sv
package dpgs_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0]  PD_VOL_ADDR    = 5'h09;
    localparam logic [4:0]  GAIN_STAT_ADDR = 5'h0a;
    localparam logic [4:0]  PD_NV_ADDR     = 5'h19;
    localparam logic [4:0]  GAIN_NV_ADDR   = 5'h1a;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int          PD_LSB         = 0;
    localparam int          PD_W           = 2;
    localparam int          GAIN_LSB       = 8;
    localparam int          POR_BIT        = 7;
    localparam int          NVWA_BIT       = 6;
    localparam logic [3:0]  PD_MASK_SINGLE = 4'h3;
    localparam logic [3:0]  PD_MASK_DUAL   = 4'hf;
    localparam logic [1:0]  GAIN_MASK_SGL  = 2'h1;
    localparam logic [1:0]  GAIN_MASK_DUAL = 2'h3;

    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [3:0]  PD_RESET       = 4'h0;
    localparam logic [1:0]  GAIN_RESET     = 2'h0;
    localparam logic [15:0] RDATA_RESET    = 16'h0000;
    localparam logic [1:0]  PD_NORMAL      = 2'b00;
    localparam logic [1:0]  PD_PULL_1K     = 2'b01;
    localparam logic [1:0]  PD_PULL_100K   = 2'b10;
    localparam logic [1:0]  PD_OPEN        = 2'b11;
    localparam logic [1:0]  LOCK_NONE      = 2'b00;
    localparam logic [1:0]  LOCK_ALL       = 2'b11;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          NV_WRITE_NS    = 100000;
    localparam int          NV_WRITE_CYC   = NV_WRITE_NS / CLK_PERIOD_NS;
    localparam int          NV_CNT_W       = 12;

    typedef enum logic [1:0] {
        DPGS_LOAD,
        DPGS_RUN,
        DPGS_ERR
    } dpgs_state_t;

endpackage

//--- hw/dpgs_nv_store.sv
`timescale 1ns/100ps
module dpgs_nv_store
    import dpgs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       wr_pd,
    input  wire logic       wr_gain,
    input  wire logic [3:0] wr_pd_val,
    input  wire logic [1:0] wr_gain_val,
    output logic      [3:0] nv_pd,
    output logic      [1:0] nv_gain,
    output logic            busy
);

    typedef struct packed {
        logic [3:0]          pd;
        logic [1:0]          gain;
        logic                busy;
        logic [NV_CNT_W-1:0] cnt;
    } dpgs_nv_t;

    // blank array reads as zero until first programmed; reset keeps it
    dpgs_nv_t s_q = '{pd: PD_RESET, gain: GAIN_RESET, busy: 1'b0, cnt: '0};
    dpgs_nv_t s_d;

    // ------------------------------------------------------------
    // write cycle timer
    // ------------------------------------------------------------
    // content lands at once, busy models the cell programming time
    always_comb
    begin
        s_d = s_q;
        if (s_q.busy)
        begin
            if (s_q.cnt == NV_CNT_W'(NV_WRITE_CYC - 1))
            begin
                s_d.busy = 1'b0;
                s_d.cnt  = '0;
            end
            else
            begin
                s_d.cnt = s_q.cnt + NV_CNT_W'(1);
            end
        end
        else if (wr_pd || wr_gain)
        begin
            s_d.busy = 1'b1;
            if (wr_pd)
            begin
                s_d.pd = wr_pd_val;
            end
            if (wr_gain)
            begin
                s_d.gain = wr_gain_val;
            end
        end
    end

    // content survives reset: it stands for the nonvolatile array
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q.busy <= 1'b0;
            s_q.cnt  <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign nv_pd   = s_q.pd;
    assign nv_gain = s_q.gain;
    assign busy    = s_q.busy;

endmodule // dpgs_nv_store

//--- hw/dpgs_out_decode.sv
`timescale 1ns/100ps
module dpgs_out_decode
    import dpgs_pkg::*;
(
    input  wire logic [3:0] pd_sel,
    input  wire logic [1:0] gain_sel,
    output logic      [1:0] out_drive_en,
    output logic      [1:0] out_pull_1k,
    output logic      [1:0] out_pull_100k,
    output logic      [1:0] out_gain_x2
);

    // ------------------------------------------------------------
    // per channel output stage control
    // ------------------------------------------------------------
    // open circuit is the case where none of the drive and pull controls is high
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_ch
        logic [1:0] sel;
        assign sel               = pd_sel[ch*PD_W +: PD_W];
        assign out_drive_en[ch]  = (sel == PD_NORMAL);
        assign out_pull_100k[ch] = (sel == PD_PULL_100K);
        assign out_pull_1k[ch]   = (sel == PD_PULL_1K);
        assign out_gain_x2[ch]   = gain_sel[ch];
    end

endmodule // dpgs_out_decode

//--- dv/dpgs_host_model.sv
`timescale 1ns/100ps
module dpgs_host_model
    import dpgs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        cmd_ready,
    input  wire logic        cmd_done,
    input  wire logic        cmd_error,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        nv_write_active_flag,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic      [4:0]  cmd_addr,
    output logic      [15:0] cmd_wdata,
    output logic             cmd_frame_end,
    output logic             timed_out
);
    // idle bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 5'h00;
        cmd_wdata = 16'h0000;
        cmd_frame_end = 1'b0;
        timed_out = 1'b0;
    end

    // hold the request until the taking edge, answer comes one edge later;
    // released lines show inverted data so stale values cannot pass
    task automatic access(input logic wr, input logic [4:0] addr,
                          input logic [15:0] wdata, output logic err,
                          output logic [15:0] rdata);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= addr;
        cmd_wdata <= wdata;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 64);
        if (cmd_ready !== 1'b1)
            timed_out = 1'b1;
        cmd_valid <= 1'b0;
        cmd_write <= ~wr;
        cmd_addr <= ~addr;
        cmd_wdata <= ~wdata;
        @(posedge sys_clk);
        err = cmd_error;
        rdata = cmd_rdata;
        if (cmd_done !== 1'b1 && cmd_error !== 1'b1)
            timed_out = 1'b1;
    endtask

    // chip select toggled to restart the command decoder
    task automatic frame_end();
        @(posedge sys_clk);
        cmd_frame_end <= 1'b1;
        @(posedge sys_clk);
        cmd_frame_end <= 1'b0;
    endtask

    // keep away from nonvolatile places while a write runs
    task automatic wait_nv_idle();
        int n;
        n = 0;
        while (nv_write_active_flag !== 1'b0 && n < 5000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (nv_write_active_flag !== 1'b0)
            timed_out = 1'b1;
    endtask
endmodule // dpgs_host_model

//--- dv/test_dpgs_regs.sv
`timescale 1ns/100ps
module test_dpgs_regs
    import dpgs_pkg::*;
;
    logic        sys_clk, rst, cmd_valid, cmd_write, cmd_frame_end;
    logic [4:0]  cmd_addr;
    logic [15:0] cmd_wdata, cmd_rdata, v;
    logic [1:0]  lock, drv, p1k, p100k, gx2;
    logic        cmd_ready, cmd_done, cmd_error, g0, g1, nvwa, host_to;
    logic [3:0]  pd;
    int          mismatches, n_compared;

    dpgs_regs #(.DUAL(1'b1)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_frame_end(cmd_frame_end), .lock_config_bits(lock),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error),
        .cmd_rdata(cmd_rdata), .channel_power_down_select(pd),
        .ch0_gain_select(g0), .ch1_gain_select(g1),
        .nv_write_active_flag(nvwa), .out_drive_en(drv),
        .out_pull_1k(p1k), .out_pull_100k(p100k), .out_gain_x2(gx2));

    dpgs_host_model i_host (
        .sys_clk(sys_clk), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .cmd_error(cmd_error), .cmd_rdata(cmd_rdata),
        .nv_write_active_flag(nvwa), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_frame_end(cmd_frame_end), .timed_out(host_to));

    // 40 MHz
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // a stuck handshake ends the run at once
    task automatic hang_chk();
        if (host_to !== 1'b0)
        begin
            mismatches++;
            end_of_test();
        end
    endtask

    // one command; refusals also check ready drops and restart the frame
    task automatic xfer(input logic wr, input logic [4:0] a,
                        input logic [15:0] d, input logic exp_err,
                        output logic [15:0] rd);
        logic e;
        i_host.access(wr, a, d, e, rd);
        hang_chk();
        chk("cmd_error", {15'h0, exp_err}, {15'h0, e});
        if (exp_err)
        begin
            chk("cmd_ready", 16'h0000, {15'h0, cmd_ready});
            i_host.frame_end();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d,
                      input logic exp_err);
        logic [15:0] dummy;
        xfer(1'b1, a, d, exp_err, dummy);
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] got;
        xfer(1'b0, a, 16'h0000, 1'b0, got);
        chk("cmd_rdata", exp, got);
    endtask

    // output stage expected from one power-down and gain setting
    task automatic out_chk(input logic [3:0] p, input logic [1:0] g);
        logic [1:0] c0, c1;
        c0 = p[1:0];
        c1 = p[3:2];
        chk("pd_select", {12'h000, p}, {12'h000, pd});
        chk("drive_en", {14'h0, c1 == 2'b00, c0 == 2'b00}, {14'h0, drv});
        chk("pull_1k", {14'h0, c1 == 2'b01, c0 == 2'b01}, {14'h0, p1k});
        chk("pull_100k", {14'h0, c1 == 2'b10, c0 == 2'b10}, {14'h0, p100k});
        chk("gain_sel", {14'h0, g}, {14'h0, g1, g0});
        chk("gain_x2", {14'h0, g}, {14'h0, gx2});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        lock = 2'b00;
        mismatches = 0;
        n_compared = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        // blank nonvolatile copies give zero gain after the first recall
        xfer(1'b0, GAIN_STAT_ADDR, 16'h0000, 1'b0, v);
        chk("status", 16'h0080, v);
        wr(GAIN_STAT_ADDR, 16'hffff, 1'b0);
        rd(GAIN_STAT_ADDR, 16'h0300);
        $display("test power_up done");

        wr(GAIN_STAT_ADDR, 16'h0100, 1'b0);
        rd(GAIN_STAT_ADDR, 16'h0100);
        for (int k = 0; k < 4; k++)
        begin
            wr(PD_VOL_ADDR, {12'hfff, 2'(3 - k), 2'(k)}, 1'b0);
            rd(PD_VOL_ADDR, {12'h000, 2'(3 - k), 2'(k)});
            out_chk({2'(3 - k), 2'(k)}, 2'b01);
        end
        $display("test volatile done");

        wr(PD_NV_ADDR, 16'hfff9, 1'b0);
        chk("nv_write_active", 16'h0001, {15'h0, nvwa});
        rd(GAIN_STAT_ADDR, 16'h0140);
        wr(GAIN_NV_ADDR, 16'h0200, 1'b1);
        wr(PD_VOL_ADDR, 16'h0003, 1'b0);
        i_host.wait_nv_idle();
        hang_chk();
        rd(GAIN_STAT_ADDR, 16'h0100);
        rd(PD_NV_ADDR, 16'h0009);
        wr(GAIN_NV_ADDR, 16'hfeff, 1'b0);
        i_host.wait_nv_idle();
        hang_chk();
        rd(GAIN_NV_ADDR, 16'h0200);
        $display("test nonvolatile done");

        @(posedge sys_clk);
        lock <= 2'b10;
        wr(PD_NV_ADDR, 16'h0000, 1'b1);
        wr(PD_VOL_ADDR, 16'h0005, 1'b0);
        rd(PD_VOL_ADDR, 16'h0005);
        lock <= 2'b11;
        wr(PD_VOL_ADDR, 16'h0000, 1'b1);
        wr(GAIN_STAT_ADDR, 16'h0000, 1'b1);
        lock <= 2'b01;
        wr(GAIN_NV_ADDR, 16'h0000, 1'b1);
        lock <= 2'b00;
        wr(5'h05, 16'h0000, 1'b1);
        xfer(1'b0, 5'h0b, 16'h0000, 1'b1, v);
        rd(PD_VOL_ADDR, 16'h0005);
        $display("test lock_error done");

        // second power event reloads from the nonvolatile copies
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        out_chk(4'h9, 2'b10);
        rd(GAIN_STAT_ADDR, 16'h0280);
        rd(GAIN_STAT_ADDR, 16'h0200);
        $display("test reload done");
        end_of_test();
    end
endmodule // test_dpgs_regs
